// file: hw/jcs_jog_ctrl.sv
/*
  Jog start control for up to 32 axes: individual forward and reverse jog,
  simultaneous jog of selected axes, speed scaling and limiting, ramped
  acceleration and deceleration, and the fresh-edge start interlocks.
  Assumes command bits synchronous to clk_i and a word-indexed register
  port with read data one cycle after the read strobe.
*/

`timescale 1ns/100ps
module jcs_jog_ctrl
  import jcs_pkg::*;
#(
  parameter int N = JCS_AXES
) (
  input  wire logic              clk_i,
  input  wire logic              nrst_i,
  input  wire logic [JCS_AW-1:0] addr_i,
  input  wire logic [JCS_DW-1:0] wr_data_i,
  input  wire logic              wr_i,
  input  wire logic              rd_i,
  output logic      [JCS_DW-1:0] rd_data_o,
  input  wire logic [N-1:0]      fwd_jog_cmd_i,
  input  wire logic [N-1:0]      rev_jog_cmd_i,
  input  wire logic              multi_axis_jog_cmd_i,
  input  wire logic              test_mode_i,
  output logic      [N-1:0]      jog_run_o,
  output logic      [N-1:0]      jog_rev_o,
  output logic      [N-1:0]      jog_decel_o,
  output logic      [$clog2(N)-1:0] speed_axis_o,
  output logic      [31:0]       speed_val_o,
  output logic                   speed_valid_o
);

  localparam int XW = $clog2(N);
  localparam int MW = $clog2(2*N);

  // -----------------------------------------------------------------------
  // Address decoding
  // -----------------------------------------------------------------------
  function automatic logic in_range(input logic [JCS_AW-1:0] a,
                                    input logic [JCS_AW-1:0] base,
                                    input int                cnt);
    in_range = (int'(a) >= int'(base)) && (int'(a) < int'(base) + cnt);
  endfunction

  jcs_mem_if #(.AW(MW), .XW(XW)) m ();

  logic              cfg_x10;
  logic [31:0]       deg_mask;
  logic [31:0]       spd_lim;
  logic [15:0]       acc_step;
  logic [15:0]       dec_step;
  logic [63:0]       sel_words;
  logic [JCS_AW-1:0] spd_off;
  logic [JCS_AW-1:0] sel_off;
  logic [1:0]        sel_idx;
  wire               spd_hit = in_range(addr_i, JCS_SPD_BASE, 2*N);
  wire               sel_hit = in_range(addr_i, JCS_SEL_BASE, JCS_SEL_WRDS);

  assign spd_off = addr_i - JCS_SPD_BASE;
  assign sel_off = addr_i - JCS_SEL_BASE;
  assign sel_idx = sel_off[1:0];

  // -----------------------------------------------------------------------
  // Speed memory
  // -----------------------------------------------------------------------
  logic [XW-1:0] scan_ptr;
  logic [XW-1:0] proc_ptr;
  logic          proc_valid;
  logic [31:0]   run_w;
  logic [15:0]   alt_data;

  assign m.wr_en     = wr_i && spd_hit;
  assign m.wr_addr   = spd_off[MW-1:0];
  assign m.wr_data   = wr_data_i;
  assign m.rd_en     = rd_i;
  assign m.rd_addr   = spd_off[MW-1:0];
  assign m.alt_sel   = !spd_hit;
  assign m.alt_data  = alt_data;
  assign m.scan_axis = scan_ptr;
  assign rd_data_o   = m.rd_data;

  jcs_speed_mem #(.N(N)) u_mem (
    .clk_i  (clk_i),
    .nrst_i (nrst_i),
    .m      (m)
  );

  always_comb begin
    alt_data = 16'h0000;
    if (sel_hit) begin
      alt_data = sel_words[16*sel_idx +: 16];
    end else begin
      case (addr_i)
        JCS_CFG:    alt_data = 16'(cfg_x10) << JCS_CFG_X10_BIT;
        JCS_DEG_LO: alt_data = deg_mask[15:0];
        JCS_DEG_HI: alt_data = deg_mask[31:16];
        JCS_LIM_LO: alt_data = spd_lim[15:0];
        JCS_LIM_HI: alt_data = spd_lim[31:16];
        JCS_ACC:    alt_data = acc_step;
        JCS_DEC:    alt_data = dec_step;
        JCS_RUN_LO: alt_data = run_w[15:0];
        JCS_RUN_HI: alt_data = run_w[31:16];
        default:    alt_data = 16'h0000;
      endcase
    end
  end

  // -----------------------------------------------------------------------
  // Configuration registers
  // -----------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cfg_x10   <= 1'b0;
      deg_mask  <= 32'h0000_0000;
      spd_lim   <= JCS_LIM_RST;
      acc_step  <= JCS_ACC_RST;
      dec_step  <= JCS_DEC_RST;
      sel_words <= 64'h0000_0000_0000_0000;
    end else if (wr_i) begin
      if (sel_hit) begin
        sel_words[16*sel_idx +: 16] <= wr_data_i;
      end
      case (addr_i)
        JCS_CFG:    cfg_x10         <= wr_data_i[JCS_CFG_X10_BIT];
        JCS_DEG_LO: deg_mask[15:0]  <= wr_data_i;
        JCS_DEG_HI: deg_mask[31:16] <= wr_data_i;
        JCS_LIM_LO: spd_lim[15:0]   <= wr_data_i;
        JCS_LIM_HI: spd_lim[31:16]  <= wr_data_i;
        JCS_ACC:    acc_step        <= wr_data_i;
        JCS_DEC:    dec_step        <= wr_data_i;
        default:    cfg_x10         <= cfg_x10;
      endcase
    end
  end

  // -----------------------------------------------------------------------
  // Axis scan and command edge capture
  // -----------------------------------------------------------------------
  // Each axis is served once per scan of N clocks; edges seen between two
  // visits are held as pending starts, taken at the visit only if the command is still on.
  logic [N-1:0] fwd_prev;
  logic [N-1:0] rev_prev;
  logic         multi_prev;
  logic [N-1:0] fwd_pend;
  logic [N-1:0] rev_pend;
  logic [N-1:0] multi_pend;
  logic [N-1:0] proc_mask;

  wire  [N-1:0] fwd_rise   = fwd_jog_cmd_i & ~fwd_prev;
  wire  [N-1:0] rev_rise   = rev_jog_cmd_i & ~rev_prev;
  wire          multi_rise = multi_axis_jog_cmd_i & ~multi_prev;

  assign proc_mask = proc_valid ? (N'(1) << proc_ptr) : '0;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      scan_ptr   <= '0;
      proc_ptr   <= '0;
      proc_valid <= 1'b0;
      fwd_prev   <= '0;
      rev_prev   <= '0;
      multi_prev <= 1'b0;
      fwd_pend   <= '0;
      rev_pend   <= '0;
      multi_pend <= '0;
    end else begin
      scan_ptr   <= (int'(scan_ptr) == N - 1) ? '0 : scan_ptr + 1'b1;
      proc_ptr   <= scan_ptr;
      proc_valid <= 1'b1;
      fwd_prev   <= fwd_jog_cmd_i;
      rev_prev   <= rev_jog_cmd_i;
      multi_prev <= multi_axis_jog_cmd_i;
      // A visit consumes or discards the pending edge of its axis.
      fwd_pend   <= test_mode_i ? '0 : (fwd_pend | fwd_rise) & ~proc_mask;
      rev_pend   <= test_mode_i ? '0 : (rev_pend | rev_rise) & ~proc_mask;
      multi_pend <= test_mode_i ? '0 :
                    (multi_pend | {N{multi_rise}}) & ~proc_mask;
    end
  end

  // -----------------------------------------------------------------------
  // Shared datapath for the axis being served
  // -----------------------------------------------------------------------
  jcs_state_t st   [N];
  logic       dir  [N];
  logic       via_multi [N];
  logic [31:0] spd [N];

  jcs_state_t  cur_st;
  logic [31:0] cur_spd;
  logic [35:0] scaled;
  logic [31:0] target;
  logic [32:0] up;
  logic [31:0] down;
  logic        fwd_go;
  logic        rev_go;
  logic        multi_go;
  logic        hold;

  assign cur_st   = st[proc_ptr];
  assign cur_spd  = spd[proc_ptr];
  assign fwd_go   = fwd_jog_cmd_i[proc_ptr] &&
                    (fwd_pend[proc_ptr] || fwd_rise[proc_ptr]);
  assign rev_go   = rev_jog_cmd_i[proc_ptr] &&
                    (rev_pend[proc_ptr] || rev_rise[proc_ptr]);
  assign multi_go = multi_axis_jog_cmd_i && sel_words[proc_ptr] &&
                    (multi_pend[proc_ptr] || multi_rise);
  assign hold     = via_multi[proc_ptr] ? multi_axis_jog_cmd_i :
                    dir[proc_ptr] ? rev_jog_cmd_i[proc_ptr] :
                    fwd_jog_cmd_i[proc_ptr];
  assign scaled   = (cfg_x10 && deg_mask[proc_ptr]) ?
                    36'(m.scan_word) * 36'(JCS_DEG_X10) :
                    36'(m.scan_word);
  assign target   = (scaled > 36'(spd_lim)) ? spd_lim :
                    scaled[31:0];
  assign up       = 33'(cur_spd) + 33'(acc_step);
  assign down     = (cur_spd > 32'(dec_step)) ?
                    cur_spd - 32'(dec_step) : 32'h0000_0000;

  jcs_state_t  next_st;
  logic        next_dir;
  logic        next_multi;
  logic [31:0] next_spd;

  always_comb begin
    next_st    = cur_st;
    next_dir   = dir[proc_ptr];
    next_multi = via_multi[proc_ptr];
    next_spd   = cur_spd;
    case (cur_st)
      JCS_IDLE: begin
        next_spd = 32'h0000_0000;
        if (!test_mode_i && (fwd_go || rev_go || multi_go)) begin
          next_st    = JCS_RUN;
          next_dir   = !fwd_go && rev_go;
          next_multi = !fwd_go && !rev_go;
          next_spd   = (32'(acc_step) < target) ? 32'(acc_step) : target;
        end
      end
      JCS_RUN: begin
        if (test_mode_i || !hold) begin
          next_st  = JCS_DECEL;
          next_spd = down;
        end else if (cur_spd < target) begin
          next_spd = (up > 33'(target)) ? target : up[31:0];
        end else if (cur_spd > target) begin
          next_spd = (down < target) ? target : down;
        end
      end
      JCS_DECEL: begin
        next_spd = down;
        if (cur_spd == 32'h0000_0000) begin
          next_st = JCS_IDLE;
        end
      end
      default: begin
        next_st  = JCS_IDLE;
        next_spd = 32'h0000_0000;
      end
    endcase
  end

  // -----------------------------------------------------------------------
  // Per-axis state and outputs
  // -----------------------------------------------------------------------
  logic run_q   [N];
  logic rev_q   [N];
  logic decel_q [N];

  for (genvar i = 0; i < N; i++) begin : g_axis
    wire hit = proc_valid && (int'(proc_ptr) == i);

    always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
        st[i]        <= JCS_IDLE;
        dir[i]       <= 1'b0;
        via_multi[i] <= 1'b0;
        spd[i]       <= 32'h0000_0000;
        run_q[i]     <= 1'b0;
        rev_q[i]     <= 1'b0;
        decel_q[i]   <= 1'b0;
      end else if (hit) begin
        st[i]        <= next_st;
        dir[i]       <= next_dir;
        via_multi[i] <= next_multi;
        spd[i]       <= next_spd;
        run_q[i]     <= next_st != JCS_IDLE;
        rev_q[i]     <= next_dir && next_st != JCS_IDLE;
        decel_q[i]   <= next_st == JCS_DECEL;
      end
    end

    assign jog_run_o[i]   = run_q[i];
    assign jog_rev_o[i]   = rev_q[i];
    assign jog_decel_o[i] = decel_q[i];
    assign run_w[i]       = run_q[i];
  end

  if (N < 32) begin : g_pad
    assign run_w[31:N] = '0;
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      speed_axis_o  <= '0;
      speed_val_o   <= 32'h0000_0000;
      speed_valid_o <= 1'b0;
    end else begin
      speed_axis_o  <= proc_ptr;
      speed_val_o   <= next_spd;
      speed_valid_o <= proc_valid;
    end
  end

endmodule

// file: hw/jcs_pkg.sv
/*
  Constants and types shared by the jog start control block: register word
  indices, field positions, reset values and the per-axis state encoding.
  Assumes a 16-bit word register port addressed by word index.
*/
package jcs_pkg;

  // ---------------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------------
  localparam int unsigned JCS_AXES     = 32;
  localparam int unsigned JCS_AW       = 10;
  localparam int unsigned JCS_DW       = 16;
  localparam int unsigned JCS_SEL_WRDS = 4;

  // ---------------------------------------------------------------------
  // Register word indices
  // ---------------------------------------------------------------------
  localparam logic [9:0] JCS_SPD_BASE = 10'h280;
  localparam logic [9:0] JCS_SEL_BASE = 10'h2C6;
  localparam logic [9:0] JCS_CFG      = 10'h2D0;
  localparam logic [9:0] JCS_DEG_LO   = 10'h2D1;
  localparam logic [9:0] JCS_DEG_HI   = 10'h2D2;
  localparam logic [9:0] JCS_LIM_LO   = 10'h2D3;
  localparam logic [9:0] JCS_LIM_HI   = 10'h2D4;
  localparam logic [9:0] JCS_ACC      = 10'h2D5;
  localparam logic [9:0] JCS_DEC      = 10'h2D6;
  localparam logic [9:0] JCS_RUN_LO   = 10'h2D7;
  localparam logic [9:0] JCS_RUN_HI   = 10'h2D8;

  // ---------------------------------------------------------------------
  // Fields and reset values
  // ---------------------------------------------------------------------
  localparam int unsigned JCS_CFG_X10_BIT = 0;
  localparam logic [31:0] JCS_LIM_RST     = 32'h0000_4E20;
  localparam logic [15:0] JCS_ACC_RST     = 16'h0064;
  localparam logic [15:0] JCS_DEC_RST     = 16'h0064;
  localparam logic [3:0]  JCS_DEG_X10     = 4'hA;

  // ---------------------------------------------------------------------
  // Axis state
  // ---------------------------------------------------------------------
  typedef enum logic [1:0] {
    JCS_IDLE  = 2'b00,
    JCS_RUN   = 2'b01,
    JCS_DECEL = 2'b11
  } jcs_state_t;

endpackage

// file: hw/jcs_mem_if.sv
/*
  Port bundle between the jog controller and its speed word memory.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/100ps
interface jcs_mem_if #(
  parameter int AW = 6,
  parameter int XW = 5
);
  logic          wr_en;
  logic [AW-1:0] wr_addr;
  logic [15:0]   wr_data;
  logic          rd_en;
  logic [AW-1:0] rd_addr;
  logic          alt_sel;
  logic [15:0]   alt_data;
  logic [15:0]   rd_data;
  logic [XW-1:0] scan_axis;
  logic [31:0]   scan_word;

  modport mem (
    input  wr_en, wr_addr, wr_data, rd_en, rd_addr, alt_sel, alt_data,
    input  scan_axis,
    output rd_data, scan_word
  );
  modport ctl (
    output wr_en, wr_addr, wr_data, rd_en, rd_addr, alt_sel, alt_data,
    output scan_axis,
    input  rd_data, scan_word
  );
endinterface

// file: hw/jcs_speed_mem.sv
/*
  Speed word memory: two 16-bit words per axis, low word at the even index.
  Holds the register read data flop, so non-memory words are passed in on
  the alternate path and leave through the same register.
  Assumes one clock and an asynchronous active-low reset.
*/
`timescale 1ns/100ps
module jcs_speed_mem
  import jcs_pkg::*;
#(
  parameter int N = JCS_AXES
) (
  input  wire logic clk_i,
  input  wire logic nrst_i,
  jcs_mem_if.mem    m
);

  logic [15:0] words [2*N];

  // -----------------------------------------------------------------------
  // Storage and registered reads
  // -----------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      for (int i = 0; i < 2*N; i++) begin
        words[i] <= 16'h0000;
      end
    end else if (m.wr_en) begin
      words[m.wr_addr] <= m.wr_data;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      m.rd_data   <= 16'h0000;
      m.scan_word <= 32'h0000_0000;
    end else begin
      m.rd_data   <= !m.rd_en ? 16'h0000 :
                     m.alt_sel ? m.alt_data : words[m.rd_addr];
      m.scan_word <= {words[{m.scan_axis, 1'b1}],
                      words[{m.scan_axis, 1'b0}]};
    end
  end

endmodule

// file: test/jcs_jog_ctrl_sva.sv
/*
  Concurrent checks on the ports of the jog start controller.
  Assumes one clock, asynchronous active-low reset and the word-indexed
  register port of the controller.
*/
`timescale 1ns/100ps
module jcs_jog_ctrl_chk
  import jcs_pkg::*;
#(
  parameter int N = JCS_AXES
) (
  input wire logic                 clk_i,
  input wire logic                 nrst_i,
  input wire logic [JCS_AW-1:0]    addr_i,
  input wire logic [JCS_DW-1:0]    wr_data_i,
  input wire logic                 wr_i,
  input wire logic                 rd_i,
  input wire logic [JCS_DW-1:0]    rd_data_o,
  input wire logic [N-1:0]         fwd_jog_cmd_i,
  input wire logic [N-1:0]         rev_jog_cmd_i,
  input wire logic                 multi_axis_jog_cmd_i,
  input wire logic                 test_mode_i,
  input wire logic [N-1:0]         jog_run_o,
  input wire logic [N-1:0]         jog_rev_o,
  input wire logic [N-1:0]         jog_decel_o,
  input wire logic [$clog2(N)-1:0] speed_axis_o,
  input wire logic [31:0]          speed_val_o,
  input wire logic                 speed_valid_o
);
  // Shadow of the speed limit and a count of cycles spent in test mode.
  logic [31:0] lim;
  logic [7:0]  tm_cnt;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      lim    <= JCS_LIM_RST;
      tm_cnt <= 8'h00;
    end else begin
      if (wr_i && addr_i == JCS_LIM_LO) lim[15:0] <= wr_data_i;
      if (wr_i && addr_i == JCS_LIM_HI) lim[31:16] <= wr_data_i;
      if (!test_mode_i) tm_cnt <= 8'h00;
      else if (tm_cnt != 8'hFF) tm_cnt <= tm_cnt + 8'h01;
    end
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  AST_RD_STAND: assert property (!$past(rd_i) |-> rd_data_o == '0)
    else $error("read data outside its cycle");
  AST_AXIS_STEP: assert property (speed_valid_o && $past(speed_valid_o)
    |-> speed_axis_o == $past(speed_axis_o) + 1'b1)
    else $error("axis scan out of order");
  AST_SPEED_CAP: assert property (speed_valid_o |-> speed_val_o <= lim)
    else $error("speed above limit");
  AST_IDLE_ZERO: assert property (speed_valid_o && !jog_run_o[speed_axis_o]
    |-> speed_val_o == 32'h0)
    else $error("idle axis with speed");
  AST_DECEL_RUN: assert property ((jog_decel_o & ~jog_run_o) == '0)
    else $error("decel without run");
  AST_REV_RUN: assert property ((jog_rev_o & ~jog_run_o) == '0)
    else $error("reverse without run");
  AST_DIR_HOLD: assert property (($past(jog_run_o) & jog_run_o
    & ($past(jog_rev_o) ^ jog_rev_o)) == '0)
    else $error("direction changed while moving");
  AST_NO_RESTART: assert property (($past(jog_decel_o) & jog_run_o
    & ~jog_decel_o) == '0)
    else $error("restart during deceleration");
  AST_TEST_IGNORE: assert property (tm_cnt > 8'(N + 2)
    |-> (jog_run_o & ~$past(jog_run_o)) == '0)
    else $error("start in test mode");
  AST_ONE_AXIS: assert property (1'b1 |-> ((jog_run_o ^ $past(jog_run_o))
    & ~(N'(1) << speed_axis_o)) == '0)
    else $error("axis changed outside its visit");
endmodule

bind jcs_jog_ctrl jcs_jog_ctrl_chk #(.N(N)) u_chk (
  .clk_i(clk_i), .nrst_i(nrst_i), .addr_i(addr_i), .wr_data_i(wr_data_i),
  .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o),
  .fwd_jog_cmd_i(fwd_jog_cmd_i), .rev_jog_cmd_i(rev_jog_cmd_i),
  .multi_axis_jog_cmd_i(multi_axis_jog_cmd_i), .test_mode_i(test_mode_i),
  .jog_run_o(jog_run_o), .jog_rev_o(jog_rev_o), .jog_decel_o(jog_decel_o),
  .speed_axis_o(speed_axis_o), .speed_val_o(speed_val_o),
  .speed_valid_o(speed_valid_o)
);

// file: test/jcs_seq_model.sv
/*
  Sequence logic model that owns the jog command bits.
  Assumes the caller invokes drive from one process at a time.
*/
`timescale 1ns/100ps
module jcs_seq_model #(
  parameter int N = 4
) (
  input  wire logic         clk_i,
  output logic      [N-1:0] fwd_o,
  output logic      [N-1:0] rev_o,
  output logic              multi_o,
  output logic              test_o
);
  initial begin
    fwd_o   = '0;
    rev_o   = '0;
    multi_o = 1'b0;
    test_o  = 1'b0;
  end

  // Commands change just after a clock edge, one update per edge.
  task automatic drive(input logic [N-1:0] f, input logic [N-1:0] r,
                       input logic m, input logic t);
    @(posedge clk_i);
    fwd_o   <= f;
    rev_o   <= r;
    multi_o <= m;
    test_o  <= t;
  endtask

  // Millimetre speed word is the real speed times one hundred.
  function automatic logic [31:0] enc_mm(input int mm_per_min);
    return 32'(mm_per_min * 100);
  endfunction
endmodule

// file: test/testbench.sv
/*
  Self-checking bench for the jog start controller with four axes.
  Assumes the register port timing and axis scan of the controller.
*/
`timescale 1ns/100ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_errors++; \
  $display("BAD %s exp=%0h got=%0h", nm, e, g); end end
module testbench import jcs_pkg::*;;
  localparam int NA = 4;
  typedef struct packed {
    logic [9:0]  a;
    logic        w;
    logic [15:0] d;
    logic [15:0] e;
  } jcs_row_t;
  jcs_row_t rows [11] = '{
    '{JCS_LIM_LO, 1'b0, 16'h0000, 16'h4E20}, '{JCS_LIM_HI, 1'b0, 16'h0, 16'h0},
    '{JCS_ACC, 1'b0, 16'h0000, 16'h0064}, '{JCS_DEC, 1'b0, 16'h0, 16'h0064},
    '{JCS_SPD_BASE, 1'b0, 16'h0, 16'h0}, '{10'h287, 1'b1, 16'h1234, 16'h1234},
    '{10'h287, 1'b1, 16'h0, 16'h0}, '{10'h2C9, 1'b1, 16'hABCD, 16'hABCD},
    '{10'h2C9, 1'b1, 16'h0, 16'h0}, '{10'h3FF, 1'b1, 16'hFFFF, 16'h0},
    '{JCS_RUN_LO, 1'b1, 16'hFFFF, 16'h0}};
  logic              clk_i = 1'b0;
  logic              nrst_i = 1'b0;
  logic [9:0]        addr_i = 10'h000;
  logic [15:0]       wr_data_i = 16'h0000;
  logic              wr_i = 1'b0;
  logic              rd_i = 1'b0;
  logic [15:0]       rd_data_o;
  logic [NA-1:0]     fwd, rev, jog_run_o, jog_rev_o, jog_decel_o;
  logic              multi, test;
  logic [1:0]        speed_axis_o;
  logic [31:0]       speed_val_o, vs, spd;
  logic              speed_valid_o, vr, vrev, vd;
  logic [15:0]       rdv;
  int                n_errors = 0;
  int                checks = 0;
  int                cyc = 0;

  jcs_jog_ctrl #(.N(NA)) DUT (
    .clk_i(clk_i), .nrst_i(nrst_i), .addr_i(addr_i), .wr_data_i(wr_data_i),
    .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o),
    .fwd_jog_cmd_i(fwd), .rev_jog_cmd_i(rev), .multi_axis_jog_cmd_i(multi),
    .test_mode_i(test), .jog_run_o(jog_run_o), .jog_rev_o(jog_rev_o),
    .jog_decel_o(jog_decel_o), .speed_axis_o(speed_axis_o),
    .speed_val_o(speed_val_o), .speed_valid_o(speed_valid_o));
  jcs_seq_model #(.N(NA)) u_seq (.clk_i(clk_i), .fwd_o(fwd), .rev_o(rev),
    .multi_o(multi), .test_o(test));

  always #25 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 6000) begin
      n_errors++;
      close_out();
    end
  end

  task automatic close_out();
    $display("checks=%0d n_errors=%0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // ---------------------------------------------------------------------
  // Register port and axis scan helpers
  // ---------------------------------------------------------------------
  task automatic wr(input logic [9:0] a, input logic [15:0] d);
    @(posedge clk_i);
    addr_i <= a; wr_data_i <= d; wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [9:0] a, output logic [15:0] d);
    @(posedge clk_i);
    addr_i <= a; rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 d = rd_data_o;
  endtask
  // Waits for the next report of axis k and keeps its outputs.
  task automatic visit(input int k);
    int t;
    t = 0;
    do begin @(posedge clk_i); #1; t++; end
    while (!(speed_valid_o === 1'b1 && speed_axis_o === 2'(k)) && t < 20);
    if (t == 20) n_errors++;
    vs = speed_val_o; vr = jog_run_o[k]; vrev = jog_rev_o[k];
    vd = jog_decel_o[k];
  endtask
  task automatic wait_run(input int k, input logic want);
    int n;
    n = 0;
    do begin visit(k); n++; end while (vr !== want && n < 8);
  endtask
  task automatic wait_dec(input int k);
    int n;
    n = 0;
    do begin visit(k); n++; end while (vd !== 1'b1 && n < 8);
  endtask
  // ---------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------
  initial begin
    repeat (2) @(posedge clk_i);
    nrst_i <= 1'b1;
    foreach (rows[i]) begin
      if (rows[i].w) wr(rows[i].a, rows[i].d);
      rd(rows[i].a, rdv);
      `CHK("reg", rows[i].e, rdv)
    end
    spd = u_seq.enc_mm(3);
    for (int a = 0; a < NA; a++) wr(JCS_SPD_BASE + 10'(2 * a), spd[15:0]);
    // Ramp up, hold, ramp down on axis 0.
    u_seq.drive(4'h1, 4'h0, 1'b0, 1'b0);
    wait_run(0, 1'b1);
    for (int i = 1; i <= 4; i++) begin
      if (i > 1) visit(0);
      `CHK("ramp", 32'((i < 4 ? i : 3) * 100), vs)
    end
    u_seq.drive(4'h0, 4'h0, 1'b0, 1'b0);
    wait_dec(0);
    `CHK("decel", 1'b1, vd)
    for (int i = 2; i >= 0; i--) begin
      `CHK("slow", 32'(i * 100), vs)
      visit(0);
    end
    `CHK("stop", 1'b0, vr)
    // Both directions at once, then a held reverse after stop.
    u_seq.drive(4'h2, 4'h2, 1'b0, 1'b0);
    wait_run(1, 1'b1);
    `CHK("fwd_wins", 1'b0, vrev)
    u_seq.drive(4'h0, 4'h2, 1'b0, 1'b0);
    wait_run(1, 1'b0);
    visit(1);
    visit(1);
    `CHK("no_rev", 1'b0, vr)
    u_seq.drive(4'h0, 4'h0, 1'b0, 1'b0);
    u_seq.drive(4'h0, 4'h2, 1'b0, 1'b0);
    wait_run(1, 1'b1);
    `CHK("rev_dir", 1'b1, vrev)
    u_seq.drive(4'h0, 4'h0, 1'b0, 1'b0);
    wait_run(1, 1'b0);
    // Command returns while axis 2 decelerates.
    u_seq.drive(4'h4, 4'h0, 1'b0, 1'b0);
    wait_run(2, 1'b1);
    visit(2);
    visit(2);
    u_seq.drive(4'h0, 4'h0, 1'b0, 1'b0);
    wait_dec(2);
    u_seq.drive(4'h4, 4'h0, 1'b0, 1'b0);
    wait_run(2, 1'b0);
    visit(2);
    `CHK("no_restart", 1'b0, vr)
    u_seq.drive(4'h0, 4'h0, 1'b0, 1'b0);
    u_seq.drive(4'h4, 4'h0, 1'b0, 1'b0);
    wait_run(2, 1'b1);
    `CHK("restart", 1'b1, vr)
    u_seq.drive(4'h0, 4'h0, 1'b0, 1'b0);
    wait_run(2, 1'b0);
    // Test mode hides a rising command on axis 3.
    u_seq.drive(4'h0, 4'h0, 1'b0, 1'b1);
    u_seq.drive(4'h8, 4'h0, 1'b0, 1'b1);
    repeat (3) visit(3);
    `CHK("test_hold", 1'b0, vr)
    u_seq.drive(4'h8, 4'h0, 1'b0, 1'b0);
    repeat (3) visit(3);
    `CHK("test_exit", 1'b0, vr)
    u_seq.drive(4'h0, 4'h0, 1'b0, 1'b0);
    u_seq.drive(4'h8, 4'h0, 1'b0, 1'b0);
    wait_run(3, 1'b1);
    `CHK("test_edge", 1'b1, vr)
    u_seq.drive(4'h0, 4'h0, 1'b0, 1'b0);
    wait_run(3, 1'b0);
    // Simultaneous start of axes 0 and 2, selection written first.
    wr(JCS_SEL_BASE, 16'h0005);
    u_seq.drive(4'h0, 4'h0, 1'b1, 1'b0);
    wait_run(2, 1'b1);
    visit(0);
    visit(1);
    `CHK("multi_sel", 4'h5, jog_run_o)
    `CHK("multi_fwd", 4'h0, jog_rev_o)
    rd(JCS_RUN_LO, rdv);
    `CHK("run_reg", 16'h0005, rdv)
    u_seq.drive(4'h0, 4'h0, 1'b0, 1'b0);
    wait_run(0, 1'b0);
    wait_run(2, 1'b0);
    `CHK("multi_stop", 4'h0, jog_run_o)
    // Degree tenfold option and speed limit.
    wr(JCS_CFG, 16'h0001);
    wr(JCS_DEG_LO, 16'h0001);
    wr(JCS_ACC, 16'h03E8);
    wr(JCS_SPD_BASE, 16'h0014);
    u_seq.drive(4'h1, 4'h0, 1'b0, 1'b0);
    wait_run(0, 1'b1);
    `CHK("deg_x10", 32'h0000_00C8, vs)
    u_seq.drive(4'h0, 4'h0, 1'b0, 1'b0);
    wait_run(0, 1'b0);
    wr(JCS_LIM_LO, 16'h0096);
    u_seq.drive(4'h2, 4'h0, 1'b0, 1'b0);
    wait_run(1, 1'b1);
    `CHK("limit", 32'h0000_0096, vs)
    visit(1);
    `CHK("limit_hold", 32'h0000_0096, vs)
    // Test mode entered while running brings the axis down.
    u_seq.drive(4'h2, 4'h0, 1'b0, 1'b1);
    wait_dec(1);
    `CHK("test_dec", 1'b1, vd)
    // Reset in mid-run clears every output.
    @(posedge clk_i);
    nrst_i <= 1'b0;
    #1 `CHK("reset_run", 4'h0, jog_run_o)
    u_seq.drive(4'h0, 4'h0, 1'b0, 1'b0);
    nrst_i <= 1'b1;
    @(posedge clk_i);
    #1 `CHK("rst_valid0", 1'b0, speed_valid_o)
    @(posedge clk_i);
    #1 `CHK("rst_valid1", 1'b1, speed_valid_o)
    `CHK("rst_idle", 4'h0, jog_run_o)
    close_out();
  end
endmodule
